// ===== rtl/pmbus_responder_cfg.svh
// Constants of the supervisory bus target: addresses, command codes,
// local register map, status bit positions, reset values and timing.
// Assumes a single 20 MHz core clock.
`ifndef PMBUS_RESPONDER_CFG_SVH
`define PMBUS_RESPONDER_CFG_SVH

// Seven-bit bus addresses
`define CFG_ADDR_LOOP_MASTER 7'h24
`define CFG_ADDR_LOOP_SLAVE  7'h25
`define CFG_ADDR_ALERT_RESP  7'h0c

// Command codes
`define CFG_CMD_CLEAR_FAULTS 8'h03
`define CFG_CMD_STORE_ALL    8'h11
`define CFG_CMD_ALERT_MASK   8'h1b
`define CFG_CMD_OPTIONS      8'hd5

// Local register offsets
`define CFG_REG_OPTIONS      3'h0
`define CFG_REG_ALERT_MASK   3'h1
`define CFG_REG_TON_RESP     3'h2
`define CFG_REG_RAMP_TIME    3'h3
`define CFG_REG_STATUS       3'h4

// Status bit positions
`define CFG_ST_UV_WARN       0
`define CFG_ST_TON_MAX       1
`define CFG_ST_VIN_UVLO      2
`define CFG_ST_COMM_ERR      3

// Option bit positions
`define CFG_OPT_SELF_RELEASE 0

// Reset values
`define CFG_RST_SELF_RELEASE 1'b1
`define CFG_RST_ALERT_MASK   8'h00
`define CFG_RST_RAMP_US      16'h03e8

// Timing
`define CFG_CLK_NS           50
`define CFG_TICK_NS          1000
`define CFG_TICK_CYC         (`CFG_TICK_NS / `CFG_CLK_NS)
`define CFG_RETRY_RAMPS      7

`endif

// ===== rtl/pmbus_pkg.sv
// Types shared by the supervisory bus target, its port checks and its bench.
// Constants live in the cfg header.
package pmbus_pkg;

    typedef enum logic [1:0] {RESP_LATCH, RESP_RESTART, RESP_IGNORE} fault_resp_e;

    typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RX_ACK, BUS_TX, BUS_TX_ACK, BUS_IGNORE} bus_state_e;

    typedef enum logic [1:0] {PWR_RUN, PWR_LATCHED, PWR_RETRY} power_state_e;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic uv_warn;
        logic ton_max;
        logic vin_uvlo;
    } fault_det_s;

    typedef struct packed {
        logic [1:0]   scl_sync;
        logic [1:0]   sda_sync;
        logic [1:0]   strap_sync;
        logic         scl_q;
        logic         sda_q;
        logic [1:0]   strap_fill;
        logic         role_done;
        logic         role_slave;
        bus_state_e   bus;
        logic         addr_ph;
        logic [2:0]   bit_cnt;
        logic [7:0]   shreg;
        logic [1:0]   nbytes;
        logic [7:0]   cmd;
        logic [7:0]   data;
        logic [7:0]   crc;
        logic         wr_sel;
        logic         is_ara;
        logic         ack_on;
        logic         tx_first;
        logic         tx_cnt;
        logic         sda_drive;
        logic         self_rel;
        logic [7:0]   mask;
        fault_resp_e  ton_resp;
        logic [15:0]  ramp_us;
        logic [7:0]   status;
        logic         alert;
        power_state_e pwr;
        logic [4:0]   tick_div;
        logic [15:0]  us_cnt;
        logic [2:0]   ramp_cnt;
        logic         restart;
        logic         store;
        logic         fet_en;
        logic         pg;
        logic [15:0]  rdata;
    } core_s;

endpackage

// ===== rtl/pec_crc8.sv
// One-byte update of the bus check byte, polynomial x^8+x^2+x+1.
// Purely combinational; the caller holds the running value.
`timescale 1ns/10ps
module pec_crc8 (
    // Running value and new byte
    input  wire logic [7:0] crc_in,
    input  wire logic [7:0] data_in,
    // Updated value
    output logic      [7:0] crc_out
);
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        end
        crc_out = c;
    end
endmodule

// ===== rtl/pmbus_alert_fault_responder.sv
// Supervisory bus target of a power converter: address match, optional
// check byte, alert line with alert-response read, and fault actions.
// Assumes bus pins and the role strap are asynchronous; fault detectors,
// ramp and power-ok inputs come from logic on ref_clk.
//
// Functional notes
// (R1) UV warning: keep switching, not in ramp, alert
// (R2) Turn-on timeout: latch, retry after seven ramps, ignore
// (R3) Works at 100 kHz and 400 kHz
// (R4) Never holds the bus clock low
// (R5) Check byte only when host clocks it
// (R6) Answers address 36 master or 37 slave
// (R7) Pulls shared alert line low on faults
// (R8) Alert response acked only while alerting
// (R9) Host reads alert response for address
// (R10) Lost arbitration on alert response backs off
// (R11) Host clears one-time event with clear-faults
// (R12) Standard mode: persisting fault re-sets after clear
// (R13) Standard mode: mask then clear releases alert
// (R14) Self-release mode default on, option bit selects
// (R15) Self-release after successful alert response read
// (R16) Store only on explicit store command
// (R17) Host sets same responses in both devices
// (R18) Clear-faults zeroes status and releases alert
// (R19) Alert mask command masks status bits
// (R20) Input UVLO: FETs off, alert, active in ramp
`timescale 1ns/10ps
`include "pmbus_responder_cfg.svh"
module pmbus_alert_fault_responder
    import pmbus_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Local register port
    input  wire reg_req_s   reg_req,
    output logic     [15:0] reg_rdata,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            alert_n_o,
    output logic            alert_n_oe,
    // Role strap, low for loop master
    input  wire logic       role_strap,
    // Converter side
    input  wire fault_det_s fault_det,
    input  wire logic       ramp_active,
    input  wire logic       pg_ok,
    output logic            fet_enable,
    output logic            power_good_flag,
    output logic            soft_start_req,
    output logic            nvm_store_req
);

    localparam core_s CORE_RST = '{
        bus:      BUS_IDLE,
        pwr:      PWR_RUN,
        ton_resp: RESP_LATCH,
        self_rel: `CFG_RST_SELF_RELEASE,
        mask:     `CFG_RST_ALERT_MASK,
        ramp_us:  `CFG_RST_RAMP_US,
        scl_sync: 2'b11,
        sda_sync: 2'b11,
        scl_q:    1'b1,
        sda_q:    1'b1,
        default:  '0
    };

    core_s      q;
    core_s      d;
    logic [6:0] own_addr;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] crc_rx;
    logic [7:0] crc_tx;
    logic       s_scl;
    logic       s_sda;
    logic       bus_start;
    logic       bus_stop;
    logic       scl_rise;
    logic       scl_fall;
    logic       tick;

    assign own_addr  = q.role_slave ? `CFG_ADDR_LOOP_SLAVE : `CFG_ADDR_LOOP_MASTER; // see (R6)
    assign s_scl     = q.scl_sync[1];
    assign s_sda     = q.sda_sync[1];
    assign rx_byte   = {q.shreg[6:0], s_sda};
    assign tx_byte   = {own_addr, 1'b0}; // see (R9)
    // Sampling at 20 MHz leaves ten or more samples per 400 kHz clock half
    assign bus_start = q.scl_q & s_scl & q.sda_q & ~s_sda; // see (R3)
    assign bus_stop  = q.scl_q & s_scl & ~q.sda_q & s_sda;
    assign scl_rise  = ~q.scl_q & s_scl;
    assign scl_fall  = q.scl_q & ~s_scl;
    assign tick      = (q.tick_div == 5'(`CFG_TICK_CYC - 1));

    pec_crc8 u_crc_rx (
        .crc_in  (q.crc),
        .data_in (rx_byte),
        .crc_out (crc_rx)
    );

    pec_crc8 u_crc_tx (
        .crc_in  (q.crc),
        .data_in (tx_byte),
        .crc_out (crc_tx)
    );

    always_comb begin
        logic [7:0] set_bits;
        logic [7:0] kept;
        logic       clear_cmd;
        logic       ara_done;
        logic       cmd_ok;
        logic [1:0] len;
        set_bits  = 8'h00;
        kept      = 8'h00;
        clear_cmd = 1'b0;
        ara_done  = 1'b0;
        cmd_ok    = 1'b0;
        len       = 2'h0;
        d         = q;
        d.restart = 1'b0;
        d.store   = 1'b0;
        d.rdata   = 16'h0000;

        d.scl_sync   = {q.scl_sync[0], scl_i};
        d.sda_sync   = {q.sda_sync[0], sda_i};
        d.strap_sync = {q.strap_sync[0], role_strap};
        d.scl_q      = q.scl_sync[1];
        d.sda_q      = q.sda_sync[1];

        // Strap taken once, after the synchroniser has filled
        d.strap_fill = {q.strap_fill[0], 1'b1};
        if (q.strap_fill == 2'b11 && !q.role_done) begin
            d.role_slave = q.strap_sync[1];
            d.role_done  = 1'b1;
        end

        // Bus engine; clock is input only (see (R4))
        if (bus_start) begin
            d.bus       = BUS_RX;
            d.addr_ph   = 1'b1;
            d.bit_cnt   = 3'h0;
            d.nbytes    = 2'h0;
            d.crc       = 8'h00;
            d.wr_sel    = 1'b0;
            d.is_ara    = 1'b0;
            d.ack_on    = 1'b0;
            d.tx_first  = 1'b0;
            d.sda_drive = 1'b0;
        end else if (bus_stop) begin
            if (q.wr_sel) begin
                case (q.cmd)
                    `CFG_CMD_CLEAR_FAULTS, `CFG_CMD_STORE_ALL: len = 2'h1;
                    `CFG_CMD_ALERT_MASK, `CFG_CMD_OPTIONS:     len = 2'h2;
                    default:                                   len = 2'h0;
                endcase
                // Trailing byte checked only if the host clocked it (see (R5))
                cmd_ok = (len != 2'h0) && (q.nbytes == len || (q.nbytes == 2'(len + 2'h1) && q.crc == 8'h00));
                if (cmd_ok) begin
                    case (q.cmd)
                        `CFG_CMD_CLEAR_FAULTS: clear_cmd = 1'b1;               // see (R18)
                        `CFG_CMD_STORE_ALL:    d.store = 1'b1;                 // see (R16)
                        `CFG_CMD_ALERT_MASK:   d.mask = q.data;                // see (R19)
                        `CFG_CMD_OPTIONS:      d.self_rel = q.data[`CFG_OPT_SELF_RELEASE]; // see (R14)
                        default: ;
                    endcase
                end else begin
                    set_bits[`CFG_ST_COMM_ERR] = 1'b1;
                end
            end
            d.bus       = BUS_IDLE;
            d.wr_sel    = 1'b0;
            d.is_ara    = 1'b0;
            d.sda_drive = 1'b0;
        end else begin
            case (q.bus)
                BUS_RX: begin
                    if (scl_rise) begin
                        d.shreg   = rx_byte;
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        if (q.bit_cnt == 3'h7) begin
                            d.crc    = crc_rx;
                            d.bus    = BUS_RX_ACK;
                            d.ack_on = 1'b0;
                            if (q.addr_ph) begin
                                d.addr_ph = 1'b0;
                                if (rx_byte[7:1] == own_addr && !rx_byte[0]) begin
                                    d.wr_sel = 1'b1; // see (R6)
                                end else if (rx_byte[7:1] == `CFG_ADDR_ALERT_RESP && rx_byte[0] && q.alert) begin
                                    d.is_ara = 1'b1; // see (R8)
                                end else begin
                                    d.bus = BUS_IGNORE;
                                end
                            end else begin
                                if (q.nbytes == 2'h0) begin
                                    d.cmd = rx_byte;
                                end
                                if (q.nbytes == 2'h1) begin
                                    d.data = rx_byte;
                                end
                                if (q.nbytes != 2'h3) begin
                                    d.nbytes = q.nbytes + 2'h1;
                                end
                            end
                        end
                    end
                end
                BUS_RX_ACK: begin
                    if (scl_fall) begin
                        d.ack_on    = ~q.ack_on;
                        d.sda_drive = ~q.ack_on;
                        if (q.ack_on && q.is_ara) begin
                            d.bus       = BUS_TX;
                            d.shreg     = tx_byte;
                            d.crc       = crc_tx;
                            d.tx_cnt    = 1'b0;
                            d.sda_drive = ~tx_byte[7];
                        end else if (q.ack_on) begin
                            d.bus       = BUS_RX;
                        end
                    end
                end
                BUS_TX: begin
                    if (scl_rise) begin
                        // Released a one, line low: lower address wins
                        if (!q.sda_drive && !s_sda) begin
                            d.bus       = BUS_IGNORE; // see (R10)
                            d.sda_drive = 1'b0;
                        end else begin
                            d.bit_cnt = q.bit_cnt + 3'h1;
                        end
                    end else if (scl_fall) begin
                        if (q.tx_first) begin
                            d.tx_first  = 1'b0;
                            d.sda_drive = ~q.shreg[7];
                        end else if (q.bit_cnt == 3'h0) begin
                            d.sda_drive = 1'b0;
                            d.bus       = BUS_TX_ACK;
                        end else begin
                            d.shreg     = {q.shreg[6:0], 1'b0};
                            d.sda_drive = ~q.shreg[6];
                        end
                    end
                end
                BUS_TX_ACK: begin
                    if (scl_rise) begin
                        d.tx_cnt = 1'b1;
                        ara_done = ~q.tx_cnt;
                        // Host ack after the address asks for the check byte
                        if (!s_sda && !q.tx_cnt) begin
                            d.bus      = BUS_TX; // see (R5)
                            d.shreg    = q.crc;
                            d.tx_first = 1'b1;
                        end else begin
                            d.bus = BUS_IGNORE;
                        end
                    end
                end
                default: ;
            endcase
        end

        // After the bus so a same-cycle local write wins
        if (reg_req.wr) begin
            case (reg_req.addr)
                `CFG_REG_OPTIONS:    d.self_rel = reg_req.wdata[`CFG_OPT_SELF_RELEASE]; // see (R14)
                `CFG_REG_ALERT_MASK: d.mask = reg_req.wdata[7:0];
                `CFG_REG_TON_RESP:   d.ton_resp = fault_resp_e'(reg_req.wdata[1:0]);
                `CFG_REG_RAMP_TIME:  d.ramp_us = reg_req.wdata;
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                `CFG_REG_OPTIONS:    d.rdata = {15'h0000, q.self_rel};
                `CFG_REG_ALERT_MASK: d.rdata = {8'h00, q.mask};
                `CFG_REG_TON_RESP:   d.rdata = {14'h0000, q.ton_resp};
                `CFG_REG_RAMP_TIME:  d.rdata = q.ramp_us;
                `CFG_REG_STATUS:     d.rdata = {4'h0, q.pwr, q.role_slave, q.alert, q.status};
                default:             d.rdata = 16'h0000;
            endcase
        end

        // Fault capture; a set in the cycle of a clear survives it
        if (fault_det.uv_warn && !ramp_active) begin
            set_bits[`CFG_ST_UV_WARN] = 1'b1; // see (R1)
        end
        if (fault_det.ton_max) begin
            set_bits[`CFG_ST_TON_MAX] = 1'b1; // see (R2)
        end
        if (fault_det.vin_uvlo) begin
            set_bits[`CFG_ST_VIN_UVLO] = 1'b1; // see (R20)
        end
        kept     = q.status & ~{8{clear_cmd}}; // see (R18)
        d.status = kept | set_bits; // see (R12)

        // Standard mode follows unmasked status; self-release latches new events
        if (!q.self_rel) begin
            d.alert = |(d.status & ~d.mask); // see (R7) (R13) (R19)
        end else begin
            d.alert = (q.alert & ~(clear_cmd | ara_done)) | (|(set_bits & ~kept & ~q.mask)); // see (R15)
        end

        // Power stage sequencing
        d.tick_div = tick ? 5'h00 : q.tick_div + 5'h01;
        case (q.pwr)
            PWR_RUN: begin
                if (fault_det.ton_max) begin
                    case (q.ton_resp)
                        RESP_LATCH: d.pwr = PWR_LATCHED; // see (R2)
                        RESP_RESTART: begin
                            d.pwr      = PWR_RETRY;
                            d.us_cnt   = 16'h0000;
                            d.ramp_cnt = 3'h0;
                        end
                        default: ;
                    endcase
                end
            end
            PWR_RETRY: begin
                if (tick) begin
                    if (q.us_cnt + 16'h0001 >= q.ramp_us) begin
                        d.us_cnt = 16'h0000;
                        if (q.ramp_cnt == 3'(`CFG_RETRY_RAMPS - 1)) begin
                            d.pwr     = PWR_RUN; // see (R2)
                            d.restart = 1'b1;
                        end else begin
                            d.ramp_cnt = q.ramp_cnt + 3'h1;
                        end
                    end else begin
                        d.us_cnt = q.us_cnt + 16'h0001;
                    end
                end
            end
            PWR_LATCHED: ;
            default: d.pwr = PWR_RUN;
        endcase
        d.fet_en = (d.pwr == PWR_RUN) && !fault_det.vin_uvlo; // see (R20)
        d.pg     = pg_ok && d.fet_en && !d.status[`CFG_ST_UV_WARN]
                   && !d.status[`CFG_ST_TON_MAX] && !d.status[`CFG_ST_VIN_UVLO]; // see (R1) (R2)
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata       = q.rdata;
    assign sda_o           = 1'b0;
    assign sda_oe          = q.sda_drive;
    assign alert_n_o       = 1'b0;
    assign alert_n_oe      = q.alert; // see (R7)
    assign fet_enable      = q.fet_en;
    assign power_good_flag = q.pg;
    assign soft_start_req  = q.restart;
    assign nvm_store_req   = q.store;

endmodule

// ===== sim/pmbus_responder_asserts.sv
// Port checks of the supervisory bus target.
// Bound from the bench; one clock domain, async reset.
`timescale 1ns/10ps
module pmbus_responder_asserts
    import pmbus_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Bus pins
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       alert_n_o,
    input wire logic       alert_n_oe,
    // Converter side
    input wire fault_det_s fault_det,
    input wire logic       pg_ok,
    input wire logic       fet_enable,
    input wire logic       power_good_flag,
    input wire logic       soft_start_req,
    input wire logic       nvm_store_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_open_drain; sda_o == 1'b0 && alert_n_o == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    // Driving with the clock high forges start or stop
    property p_drive_low; $rose(sda_oe) |-> !$past(scl_i); endproperty
    a_drive_low: assert property (p_drive_low) else $error("data driven in high clock");
    property p_uvlo_off; fault_det.vin_uvlo |=> !fet_enable; endproperty
    a_uvlo_off: assert property (p_uvlo_off) else $error("fets on in uvlo");
    property p_pg_ok; !pg_ok |=> !power_good_flag; endproperty
    a_pg_ok: assert property (p_pg_ok) else $error("power good without comparator");
    property p_keep_sw;
        fet_enable && !fault_det.ton_max && !$past(fault_det.ton_max) && !$past(fault_det.ton_max, 2)
            && !fault_det.vin_uvlo |=> fet_enable;
    endproperty
    a_keep_sw: assert property (p_keep_sw) else $error("switching dropped");
    property p_retry_pulse; soft_start_req |=> !soft_start_req; endproperty
    a_retry_pulse: assert property (p_retry_pulse) else $error("long retry pulse");
    property p_retry_on; soft_start_req && !fault_det.vin_uvlo |-> !$past(fet_enable) ##[0:1] fet_enable; endproperty
    a_retry_on: assert property (p_retry_on) else $error("retry without power up");
    property p_store_stop; nvm_store_req |-> scl_i && sda_i; endproperty
    a_store_stop: assert property (p_store_stop) else $error("store before stop");
    c_retry: cover property (soft_start_req);
    c_store: cover property (nvm_store_req);
    c_release: cover property ($fell(alert_n_oe));
endmodule

// ===== sim/smbus_host_model.sv
// Behavioural bus host: start, stop, byte write, byte read.
// The bench forms the wired data level with a pull-up.
`timescale 1ns/10ps
module smbus_host_model (
    // Bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic s);
        #100 sda_low = !b;
        #100 scl = 1'b1;
        #190 s = sda_line;
        #10 scl = 1'b0;
    endtask
    task automatic start();
        sda_low = 1'b1;
        #200 scl = 1'b0;
    endtask
    // Idle lets the target finish
    task automatic stop();
        #100 sda_low = 1'b1;
        #100 scl = 1'b1;
        #100 sda_low = 1'b0;
        #400;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(!ack_it, s);
    endtask
endmodule

// ===== sim/test_pmbus_alert_fault_responder.sv
// Self-checking bench of the supervisory bus target.
// Host model on the bus pins, registers via the local port.
`timescale 1ns/10ps
module test_pmbus_alert_fault_responder
    import pmbus_pkg::*;
;
    logic        ref_clk, rst, scl_i, sda_i, sda_o, sda_oe, alert_n_o, alert_n_oe, host_low, ack;
    logic        role_strap, ramp_active, pg_ok, fet_enable, power_good_flag, soft_start_req, nvm_store_req;
    reg_req_s    reg_req;
    fault_det_s  fault_det;
    logic [15:0] reg_rdata;
    logic [7:0]  pq[$];
    int          mismatches, check_count, stores, n;
    logic [2:0]  ra[8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h0, 3'h0};
    logic [15:0] rw[8] = '{16'h00a5, 16'h0000, 16'h0001, 16'h0001, 16'hffff, 16'h00ff, 16'h0000, 16'h0001};
    logic [15:0] rx[8] = '{16'h00a5, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    logic [15:0] rv[5] = '{16'h0001, 16'h0000, 16'h0000, 16'h03e8, 16'h0000};
    assign sda_i = !(host_low || sda_oe);
    smbus_host_model i_host (.scl(scl_i), .sda_low(host_low), .sda_line(sda_i));
    pmbus_alert_fault_responder i_dut (.ref_clk, .rst, .reg_req, .reg_rdata, .scl_i, .sda_i, .sda_o, .sda_oe,
        .alert_n_o, .alert_n_oe, .role_strap, .fault_det, .ramp_active, .pg_ok, .fet_enable, .power_good_flag,
        .soft_start_req, .nvm_store_req);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk) reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) reg_req <= '0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        @(posedge ref_clk) reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge ref_clk) reg_req <= '0;
        #1 check(reg_rdata, e);
    endtask
    task automatic send(input logic [7:0] q[$], output logic ok);
        logic a;
        ok = 1'b1;
        i_host.start();
        foreach (q[i]) begin
            i_host.wbyte(q[i], a);
            ok &= a;
        end
        i_host.stop();
        tick(6);
    endtask
    task automatic ara(input logic e);
        logic a;
        logic [7:0] b;
        i_host.start();
        i_host.wbyte(8'h19, a);
        check(a, e);
        if (a === 1'b1) begin
            i_host.rbyte(1'b0, b);
            check(b, 8'h48);
        end
        i_host.stop();
        tick(6);
    endtask
    task automatic pulse(input fault_det_s f, input logic r);
        @(posedge ref_clk) fault_det <= f;
        ramp_active <= r;
        @(posedge ref_clk) fault_det <= '0;
        ramp_active <= 1'b0;
        tick(4);
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (q[i]) begin
            c ^= q[i];
            repeat (8) c = (c << 1) ^ (c[7] ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end
    always @(posedge ref_clk) if (nvm_store_req === 1'b1) stores++;
    initial begin
        rst = 1'b1;
        reg_req = '0;
        role_strap = 1'b0;
        fault_det = '0;
        ramp_active = 1'b0;
        pg_ok = 1'b1;
        tick(12);
        rst <= 1'b0;
        tick(6);
        check({fet_enable, power_good_flag}, 2'b11);
        for (int i = 0; i < 5; i++) rdc(3'(i), rv[i]);
        foreach (ra[i]) begin
            wr(ra[i], rw[i]);
            rdc(ra[i], rx[i]);
        end
        send('{8'h4a, 8'h1b, 8'h07}, ack);
        check(ack, 1'b0);
        send('{8'h48, 8'h1b, 8'h07}, ack);
        check(ack, 1'b1);
        rdc(3'h1, 16'h0007);
        send('{8'h48, 8'h1b, 8'h00}, ack);
        pulse(3'b100, 1'b1);
        rdc(3'h4, 16'h0000);
        pulse(3'b100, 1'b0);
        rdc(3'h4, 16'h0101);
        check({fet_enable, power_good_flag, alert_n_oe}, 3'b101);
        ara(1'b1);
        check(alert_n_oe, 1'b0);
        ara(1'b0);
        send('{8'h48, 8'h03}, ack);
        rdc(3'h4, 16'h0000);
        // Standard mode, persistent fault
        wr(3'h0, 16'h0000);
        @(posedge ref_clk) fault_det.uv_warn <= 1'b1;
        send('{8'h48, 8'h03}, ack);
        check(alert_n_oe, 1'b1);
        send('{8'h48, 8'h1b, 8'h01}, ack);
        send('{8'h48, 8'h03}, ack);
        check(alert_n_oe, 1'b0);
        @(posedge ref_clk) fault_det <= '0;
        send('{8'h48, 8'h1b, 8'h00}, ack);
        send('{8'h48, 8'h03}, ack);
        wr(3'h0, 16'h0001);
        pq = '{8'h48, 8'h1b, 8'h03};
        pq.push_back(crc8(pq));
        send(pq, ack);
        rdc(3'h1, 16'h0003);
        pq[2] = 8'h00;
        send(pq, ack);
        rdc(3'h1, 16'h0003);
        rdc(3'h4, 16'h0108);
        send('{8'h48, 8'h03}, ack);
        send('{8'h48, 8'h1b, 8'h00}, ack);
        check(stores, 0);
        send('{8'h48, 8'h11}, ack);
        check(stores, 1);
        // 1 us ramp keeps the retry short
        pulse(3'b010, 1'b0);
        check(fet_enable, 1'b0);
        n = 0;
        while (soft_start_req !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            summarize();
        end
        check(n > 120 && n < 170, 1'b1);
        tick(2);
        check(fet_enable, 1'b1);
        send('{8'h48, 8'h03}, ack);
        wr(3'h2, 16'h0002);
        pulse(3'b010, 1'b0);
        tick(20);
        check(fet_enable, 1'b1);
        wr(3'h2, 16'h0000);
        pulse(3'b010, 1'b0);
        tick(200);
        check({fet_enable, power_good_flag}, 2'b00);
        @(posedge ref_clk) rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(6);
        check(fet_enable, 1'b1);
        rdc(3'h2, 16'h0000);
        @(posedge ref_clk) fault_det.vin_uvlo <= 1'b1;
        tick(4);
        check({fet_enable, power_good_flag, alert_n_oe}, 3'b001);
        @(posedge ref_clk) fault_det <= '0;
        pg_ok <= 1'b0;
        tick(4);
        check({fet_enable, power_good_flag}, 2'b10);
        summarize();
    end
endmodule
bind pmbus_alert_fault_responder pmbus_responder_asserts i_chk (.ref_clk, .rst, .scl_i, .sda_i, .sda_o,
    .sda_oe, .alert_n_o, .alert_n_oe, .fault_det, .pg_ok, .fet_enable, .power_good_flag, .soft_start_req,
    .nvm_store_req);
